// file: logic/dram_ctl_defines.svh
// timing and geometry constants for the strobe-driven memory controller
`ifndef DRAM_CTL_DEFINES_SVH
`define DRAM_CTL_DEFINES_SVH
`define CLK_PERIOD_NS 10
`define ADDR_BITS 10
`define DATA_BITS 4
`define ROW_COUNT 1024
`define REFRESH_WINDOW_NS 16000000
`define POWERUP_PAUSE_NS 200000
`define INIT_CYCLES 8
// strobe phase lengths, least times rounded up to whole cycles
`define PRECHARGE_NS 60
`define PRECHARGE_CYC ((`PRECHARGE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ROW_HOLD_NS 20
`define ROW_HOLD_CYC ((`ROW_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define COL_LOW_NS 40
`define COL_LOW_CYC ((`COL_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define COL_HIGH_NS 10
`define COL_HIGH_CYC ((`COL_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ROW_LOW_NS 80
`define ROW_LOW_CYC ((`ROW_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define COL_LEAD_NS 10
`define COL_LEAD_CYC ((`COL_LEAD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// extra column-low cycles on reads so returned data clears the three-stage input synchroniser
`define SYNC_CYC 3
// refresh interval per row, longest time rounded down
`define REFRESH_EVERY_CYC (`REFRESH_WINDOW_NS / `ROW_COUNT / `CLK_PERIOD_NS)
`define POWERUP_CYC (`POWERUP_PAUSE_NS / `CLK_PERIOD_NS)
`endif

// file: logic/dram_ctl_pkg.sv
// types shared by the memory controller
package dram_ctl_pkg;
	typedef struct packed {
		logic row_strobe_n;
		logic col_strobe_n;
		logic write_sel_n;
		logic out_gate_n;
		logic [9:0] multiplexed_addr_pins;
	} dram_pins_t;
	typedef struct packed {
		logic write;
		logic [19:0] addr;
		logic [3:0] wdata;
	} dram_req_t;
	typedef enum logic [3:0] {
		ST_POWERUP = 4'h0,
		ST_IDLE = 4'h1,
		ST_ROW = 4'h3,
		ST_COL = 4'h2,
		ST_COLHI = 4'h6,
		ST_CLOSE = 4'h7,
		ST_PRE = 4'h5,
		ST_RF_LEAD = 4'h4,
		ST_RF_ROW = 4'hc
	} dram_state_t;
endpackage : dram_ctl_pkg

// file: logic/dram_ctl.sv
// host-side controller driving a 1M x 4 strobe-addressed dynamic memory
`include "dram_ctl_defines.svh"
//
// Functional notes
// R1: twenty-bit address sent as ten row bits then ten column bits.
// R2: address driven stable before each strobe falls.
// R3: device passes column address while column strobe high, holds it after fall.
// R4: page mode keeps row open and walks successive columns.
// R5: read data sampled after the column strobe access time.
// R6: write select high means read, low means write.
// R7: device ignores data pins during reads.
// R8: early write: write select falls before column strobe, outputs float.
// R9: device drives data only while column strobe and output gate low.
// R10: device drives only with both strobes and output gate low; the model keeps driving with the row strobe high during a hidden refresh.
// R11: read data has the polarity of the written data, unlatched.
// R12: device latches address and write data at the capture points.
// R13: raise output gate before driving data for a write.
// R14: refresh all 1024 rows within 16 ms.
// R15: ordinary cycles refresh the row they open.
// R16: row-only refresh keeps column strobe high.
// R17: hidden refresh keeps column strobe low, device ignores address.
// R18: column-first refresh lowers column strobe before row strobe.
// R19: device takes the refresh row from its own counter.
// R20: wait 200 us then eight init cycles including a refresh.
// R21: device counter advances one row per column-first refresh.
module dram_ctl
	import dram_ctl_pkg::*;
#(
	parameter int POWERUP_CYCLES = `POWERUP_CYC,
	parameter int REFRESH_CYCLES = `REFRESH_EVERY_CYC
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic req_valid,
	output logic req_ready,
	input wire dram_req_t req,
	output logic rsp_valid,
	output logic [3:0] rsp_data,
	output logic init_done,
	output dram_pins_t pins,
	input wire logic [3:0] data_pins_i,
	output logic [3:0] data_pins_o,
	output logic data_pins_oe
);
	////////////////////////////////////////////////////////////////////////
	dram_state_t state_q;
	logic [15:0] wait_q;
	logic [17:0] pwr_q;
	logic [15:0] rf_timer_q;
	logic rf_due_q;
	logic [3:0] init_q;
	logic [9:0] open_row_q;
	logic row_open_q;
	logic write_q;
	logic [9:0] col_q;
	logic [3:0] wdata_q;
	logic [3:0] s1_q, s2_q, s3_q;
	logic [3:0] rdata_stable;
	logic in_init;
	logic take;
	logic page_hit;

	assign in_init = (init_q != 4'(`INIT_CYCLES));
	assign init_done = !in_init;
	assign page_hit = row_open_q && (req.addr[19:10] == open_row_q);
	// new work is accepted between columns of an open row or from idle
	// between columns only a same-row request is taken, and only once the strobe high time is over
	assign req_ready = init_done && !rf_due_q &&
		(state_q == ST_IDLE || (state_q == ST_COLHI && wait_q == '0 && page_hit));
	assign take = req_valid && req_ready;

	////////////////////////////////////////////////////////////////////////
	// data pin input: three stages, a change counts when stages two and three agree
	always_ff @(posedge clk) begin
		s1_q <= data_pins_i;
		s2_q <= s1_q;
		s3_q <= s2_q;
	end
	assign rdata_stable = (s2_q == s3_q) ? s3_q : rsp_data;

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pwr_q <= '0;
		end else if (pwr_q != 18'(POWERUP_CYCLES)) begin
			pwr_q <= pwr_q + 18'h1; // [R20]
		end
	end

	// refresh pacing; one column-first cycle per interval covers all rows in time
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rf_timer_q <= '0;
			rf_due_q <= 1'b0;
		end else begin
			if (rf_timer_q == 16'(REFRESH_CYCLES - 1)) begin
				rf_timer_q <= '0;
			end else begin
				rf_timer_q <= rf_timer_q + 16'h1;
			end
			// set wins over the clear taken at refresh start
			if (rf_timer_q == 16'(REFRESH_CYCLES - 1)) begin
				rf_due_q <= 1'b1; // [R14] [R21]
			end else if (state_q == ST_RF_LEAD && wait_q == '0) begin
				rf_due_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_q <= ST_POWERUP;
			wait_q <= '0;
			init_q <= '0;
			row_open_q <= 1'b0;
			open_row_q <= '0;
			write_q <= 1'b0;
			col_q <= '0;
			wdata_q <= '0;
			pins <= '{row_strobe_n: 1'b1, col_strobe_n: 1'b1, write_sel_n: 1'b1, out_gate_n: 1'b1,
				multiplexed_addr_pins: 10'h000};
			data_pins_o <= '0;
			data_pins_oe <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_data <= '0;
		end else begin
			rsp_valid <= 1'b0;
			if (wait_q != '0) begin
				wait_q <= wait_q - 16'h1;
			end
			case (state_q)
			ST_POWERUP: begin
				if (pwr_q == 18'(POWERUP_CYCLES)) begin
					state_q <= ST_PRE;
					wait_q <= 16'(`PRECHARGE_CYC);
				end
			end
			ST_IDLE: begin
				if (in_init || rf_due_q) begin
					// column-first refresh: column strobe leads the row strobe
					pins.col_strobe_n <= 1'b0; // [R18]
					pins.write_sel_n <= 1'b1;
					state_q <= ST_RF_LEAD;
					wait_q <= 16'(`COL_LEAD_CYC);
				end else if (take) begin
					// row address on the pins one cycle before the row strobe
					pins.multiplexed_addr_pins <= req.addr[19:10]; // [R1] [R2]
					open_row_q <= req.addr[19:10];
					col_q <= req.addr[9:0];
					write_q <= req.write;
					wdata_q <= req.wdata;
					state_q <= ST_ROW;
					wait_q <= 16'(`ROW_HOLD_CYC);
				end
			end
			ST_ROW: begin
				// column strobe still high: the row phase alone refreshes the row we supplied
				pins.row_strobe_n <= 1'b0; // [R15] [R16]
				row_open_q <= 1'b1;
				if (!pins.row_strobe_n && wait_q == '0) begin
					// column address flows through before the column strobe falls
					pins.multiplexed_addr_pins <= col_q; // [R1] [R3]
					pins.write_sel_n <= !write_q; // [R6] [R8]
					pins.out_gate_n <= write_q; // [R13]
					data_pins_o <= wdata_q;
					data_pins_oe <= write_q; // [R12]
					state_q <= ST_COL;
					// reads keep the column open until the synchroniser has settled
					wait_q <= write_q ? 16'(`COL_LOW_CYC) : 16'(`COL_LOW_CYC + `SYNC_CYC); // [R5]
				end
			end
			ST_COL: begin
				pins.col_strobe_n <= 1'b0; // [R2]
				if (!pins.col_strobe_n && wait_q == '0) begin
					if (!write_q) begin
						rsp_valid <= 1'b1; // [R5] [R11]
						rsp_data <= rdata_stable;
					end
					pins.col_strobe_n <= 1'b1; // [R9]
					pins.out_gate_n <= 1'b1;
					pins.write_sel_n <= 1'b1;
					data_pins_oe <= 1'b0;
					state_q <= ST_COLHI;
					wait_q <= 16'(`COL_HIGH_CYC);
				end
			end
			ST_COLHI: begin
				if (take && page_hit && wait_q == '0) begin
					// page mode: same row, next column
					pins.multiplexed_addr_pins <= req.addr[9:0]; // [R4]
					col_q <= req.addr[9:0];
					write_q <= req.write;
					pins.write_sel_n <= !req.write; // [R8]
					pins.out_gate_n <= req.write; // [R13]
					data_pins_o <= req.wdata;
					data_pins_oe <= req.write;
					state_q <= ST_COL;
					wait_q <= req.write ? 16'(`COL_LOW_CYC) : 16'(`COL_LOW_CYC + `SYNC_CYC); // [R5]
				end else if (wait_q == '0 && (!req_valid || !page_hit || rf_due_q)) begin
					state_q <= ST_CLOSE;
				end
			end
			ST_CLOSE: begin
				pins.row_strobe_n <= 1'b1;
				row_open_q <= 1'b0;
				state_q <= ST_PRE;
				wait_q <= 16'(`PRECHARGE_CYC);
			end
			ST_PRE: begin
				if (wait_q == '0) begin
					state_q <= ST_IDLE;
				end
			end
			ST_RF_LEAD: begin
				if (wait_q == '0) begin
					pins.row_strobe_n <= 1'b0; // [R18] [R19]
					state_q <= ST_RF_ROW;
					wait_q <= 16'(`ROW_LOW_CYC);
				end
			end
			ST_RF_ROW: begin
				if (wait_q == '0) begin
					pins.row_strobe_n <= 1'b1;
					pins.col_strobe_n <= 1'b1;
					if (in_init) begin
						init_q <= init_q + 4'h1; // [R20]
					end
					state_q <= ST_PRE;
					wait_q <= 16'(`PRECHARGE_CYC);
				end
			end
			default: begin
				state_q <= ST_IDLE;
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	chk_refresh_lead: assert property (@(posedge clk) disable iff (!reset_n) // [R18]
		(state_q == ST_RF_LEAD && wait_q == '0) |=> !pins.row_strobe_n && !pins.col_strobe_n)
		else $error("refresh row strobe without leading column strobe");
	chk_gate_before_drive: assert property (@(posedge clk) disable iff (!reset_n) // [R13]
		data_pins_oe |-> pins.out_gate_n && (!$rose(data_pins_oe) || $past(pins.out_gate_n)))
		else $error("data driven with output gate low");
	chk_write_sel_early: assert property (@(posedge clk) disable iff (!reset_n) // [R8]
		$fell(pins.col_strobe_n) && data_pins_oe |-> !pins.write_sel_n && $past(!pins.write_sel_n))
		else $error("write select not ahead of column strobe");
	chk_col_addr_stable: assert property (@(posedge clk) disable iff (!reset_n) // [R2]
		$fell(pins.col_strobe_n) && state_q == ST_COL |-> $stable(pins.multiplexed_addr_pins))
		else $error("address moved at column strobe");
	chk_row_before_col: assert property (@(posedge clk) disable iff (!reset_n) // [R1]
		$fell(pins.col_strobe_n) && state_q == ST_COL |-> !pins.row_strobe_n)
		else $error("column strobe with row closed");
	chk_read_resp: assert property (@(posedge clk) disable iff (!reset_n) // [R5]
		rsp_valid |-> $past(!pins.col_strobe_n, 1) && $past(!pins.out_gate_n, 1))
		else $error("read data taken without strobe and gate low");
	chk_refresh_served: assert property (@(posedge clk) disable iff (!reset_n) // [R14]
		$rose(rf_due_q) && init_done |-> ##[1:60] (state_q == ST_RF_LEAD))
		else $error("refresh not started in time");
	chk_init_gate: assert property (@(posedge clk) disable iff (!reset_n) // [R20]
		!init_done |-> !req_ready)
		else $error("request accepted before initialisation");
	cov_read: cover property (@(posedge clk) disable iff (!reset_n) rsp_valid);
	cov_page: cover property (@(posedge clk) disable iff (!reset_n) state_q == ST_COLHI ##[1:4] state_q == ST_COL);
	cov_refresh: cover property (@(posedge clk) disable iff (!reset_n) state_q == ST_RF_ROW && init_done);
endmodule : dram_ctl

// file: dv/dram_model.sv
// behavioural model of the 1M x 4 strobe-addressed memory device
module dram_model
	import dram_ctl_pkg::*;
#(
	parameter int ACCESS_NS = 20
) (
	input wire dram_pins_t pins,
	input wire logic [3:0] dq_in,
	output logic [3:0] dq_out,
	output logic dq_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] mem [logic [19:0]];
	logic [9:0] row_q, col_q, rf_row_q;
	logic [3:0] rd_q;
	logic row_open_q, col_open_q, early_q, valid_q;
	int row_opens, cbr_count;
	initial begin
		row_q = '0; col_q = '0; rf_row_q = '0; rd_q = '0;
		row_open_q = 1'b0; col_open_q = 1'b0; early_q = 1'b0; valid_q = 1'b0;
		row_opens = 0; cbr_count = 0;
	end
	////////////////////////////////////////////////////////////////
	always @(negedge pins.row_strobe_n) begin
		if (!pins.col_strobe_n) begin // column-first or hidden refresh: pins ignored
			rf_row_q = rf_row_q + 10'h001; // wraps after the last row
			cbr_count++;
		end else begin
			row_q = pins.multiplexed_addr_pins;
			row_open_q = 1'b1;
			row_opens++;
		end
	end
	always @(posedge pins.row_strobe_n) begin
		row_open_q = 1'b0;
		early_q = 1'b0;
	end
	always @(negedge pins.col_strobe_n) if (row_open_q) begin
		col_q = pins.multiplexed_addr_pins; // open row kept, column held at fall
		col_open_q = 1'b1;
		early_q = !pins.write_sel_n;
		if (!pins.write_sel_n) mem[{row_q, col_q}] = dq_in; // data pins only read on writes
		rd_q = mem.exists({row_q, col_q}) ? mem[{row_q, col_q}] : 4'h0;
		#ACCESS_NS valid_q = 1'b1;
	end
	always @(posedge pins.col_strobe_n) begin
		col_open_q = 1'b0;
		valid_q = 1'b0;
	end
	// hidden refresh keeps the column open, so data stays out while the row strobe cycles
	assign dq_oe = col_open_q && !pins.col_strobe_n && !pins.out_gate_n && !early_q;
	assign dq_out = valid_q ? rd_q : ~rd_q; // unlatched, same polarity
endmodule : dram_model

// file: dv/dram_ctl_tb_top.sv
// self-checking bench for the strobe-driven memory controller
module dram_ctl_tb_top
	import dram_ctl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int REFRESH_EVERY = 200;
	logic clk, reset_n, req_valid, req_ready, rsp_valid, init_done, data_pins_oe, dev_oe;
	logic [3:0] rsp_data, data_pins_o, dev_dq, last_q, data_bus;
	dram_req_t req;
	dram_pins_t pins;
	int fail_count, comparisons, clash;
	dram_ctl #(.POWERUP_CYCLES(20), .REFRESH_CYCLES(REFRESH_EVERY)) dut (.clk(clk), .reset_n(reset_n),
		.req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.init_done(init_done), .pins(pins), .data_pins_i(data_bus), .data_pins_o(data_pins_o),
		.data_pins_oe(data_pins_oe));
	dram_model #(.ACCESS_NS(20)) device (.pins(pins), .dq_in(data_bus), .dq_out(dev_dq), .dq_oe(dev_oe));
	// a released bus shows the inverse of its last value instead of a simulator guess
	assign data_bus = data_pins_oe ? data_pins_o : (dev_oe ? dev_dq : ~last_q);
	always @(posedge clk) begin
		if (!reset_n) begin
			last_q <= 4'h0;
			clash <= 0;
		end else begin
			if (data_pins_oe || dev_oe) last_q <= data_bus;
			if (data_pins_oe && dev_oe) clash <= clash + 1;
		end
	end
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : check
	task automatic tally_and_finish();
		$display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : tally_and_finish
	// keep leaves the request raised so a same-row follower can continue the page
	task automatic issue(input logic wr, input logic [19:0] a, input logic [3:0] d, input logic keep);
		int n;
		n = 0;
		req = '{write: wr, addr: a, wdata: d};
		req_valid = 1'b1;
		while (req_ready !== 1'b1 && n < 300) begin
			@(posedge clk);
			#1;
			n++;
		end
		check(n < 300, 1'b1);
		@(posedge clk);
		#1;
		// a dropped request stays low across one edge before the next call raises it
		if (!keep) begin
			req_valid = 1'b0;
			@(posedge clk);
			#1;
		end
	endtask : issue
	task automatic read_expect(input logic [19:0] a, input logic [3:0] exp);
		int n;
		n = 0;
		issue(1'b0, a, 4'h0, 1'b0);
		while (rsp_valid !== 1'b1 && n < 40) begin
			@(posedge clk);
			#1;
			n++;
		end
		check(n < 40, 1'b1);
		check(rsp_data, exp);
	endtask : read_expect
	////////////////////////////////////////////////////////////////
	task automatic init_phase();
		int n;
		n = 0;
		check({pins.row_strobe_n, pins.col_strobe_n, data_pins_oe, req_ready}, 4'hc);
		reset_n = 1'b1;
		while (init_done !== 1'b1 && n < 2000) begin
			@(posedge clk);
			#1;
			n++;
		end
		check(device.cbr_count, 8);
		check(device.row_opens, 0);
	endtask : init_phase
	task automatic rw_corners();
		logic [19:0] a [5] = '{20'h00000, 20'h003ff, 20'hffc00, 20'hfffff, 20'h5a5a5};
		logic [3:0] d [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hf};
		for (int i = 0; i < 5; i++) issue(1'b1, a[i], d[i], 1'b0);
		for (int i = 0; i < 5; i++) read_expect(a[i], d[i]);
	endtask : rw_corners
	task automatic page_walk();
		logic [9:0] c [4] = '{10'h000, 10'h3ff, 10'h155, 10'h2aa};
		int o0, c0;
		o0 = device.row_opens;
		c0 = device.cbr_count;
		// refreshes before the first accept open no extra row, later ones reopen it once each
		for (int i = 0; i < 4; i++) begin
			issue(1'b1, {10'h2a5, c[i]}, 4'h3 + 4'(i), i < 3);
			if (i == 0) c0 = device.cbr_count;
		end
		check(device.row_opens - o0, 1 + device.cbr_count - c0);
		for (int i = 0; i < 4; i++) read_expect({10'h2a5, c[i]}, 4'h3 + 4'(i));
	endtask : page_walk
	task automatic refresh_idle();
		int c0, dc;
		c0 = device.cbr_count;
		repeat (REFRESH_EVERY * 5) @(posedge clk);
		#1;
		dc = device.cbr_count - c0;
		check(dc >= 4 && dc <= 6, 1'b1);
		read_expect(20'h5a5a5, 4'hf);
	endtask : refresh_idle
	////////////////////////////////////////////////////////////////
	initial begin
		reset_n = 1'b0; req_valid = 1'b0; req = '0;
		fail_count = 0; comparisons = 0;
		repeat (10) @(posedge clk);
		#1;
		init_phase();
		rw_corners();
		page_walk();
		refresh_idle();
		check(clash, 0);
		tally_and_finish();
	end
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		tally_and_finish();
	end
endmodule : dram_ctl_tb_top
